// ### dv/testbench.sv
// Self-checking bench for the transmit drive monitor block
`default_nettype none
module testbench;
    import txdm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [1:0] PAT [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    logic        clk_sys = 1'b0;
    logic        rst, transmitter_on, run, sym_pos, sym_neg, drop_mon;
    logic        tx_line_clock, tx_positive_rail_in, tx_negative_rail_in;
    logic        monitor_plus_in, monitor_minus_in, line_out_plus;
    logic        line_out_minus, line_out_oe_n, drive_fault_flag, irq;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_rresp, last_bresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    txdm_drive_monitor i_dut (
        .clk_sys, .rst, .tx_line_clock, .tx_positive_rail_in,
        .tx_negative_rail_in, .transmitter_on, .monitor_plus_in,
        .monitor_minus_in, .line_out_plus, .line_out_minus, .line_out_oe_n,
        .drive_fault_flag, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    txdm_line_partner i_line (
        .run, .sym_pos, .sym_neg, .drop_mon, .line_out_plus,
        .line_out_minus, .line_out_oe_n, .tx_line_clock,
        .tx_positive_rail_in, .tx_negative_rail_in, .monitor_plus_in,
        .monitor_minus_in
    );

    // ------------------------------------------------------------
    // Clock, hang guard and reporting
    // ------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;

    // Whole run is about 2500 cycles, so this only trips on a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Register access, one transfer at a time
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        last_bresp = s_axi_bresp;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [31:0] exp);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        last_rresp = s_axi_rresp;
        chk(what, exp, s_axi_rdata);
    endtask

    // Offer one symbol and let it reach the line for n bit periods
    task automatic sym(input logic p, input logic n, input int bits);
        @(posedge clk_sys);
        sym_pos <= p;
        sym_neg <= n;
        repeat (bits) @(posedge tx_line_clock);
        repeat (4) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        {transmitter_on, run, sym_pos, sym_neg, drop_mon} <= 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
        {s_axi_arvalid, s_axi_rready} <= 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
        s_axi_wstrb <= 4'hf;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("oe_n", 1, line_out_oe_n);
        chk("fault", 0, drive_fault_flag);
        rd_chk("ctrl", TXDM_OFS_CTRL, 0);
        rd_chk("mask", TXDM_OFS_INT_MASK, 0);
        rd_chk("odd_addr", 4'h1, 0);
        chk("rresp", TXDM_RESP_SLVERR, last_rresp);
        transmitter_on <= 1'b1;
        wr(TXDM_OFS_CTRL, 32'h3);
        chk("bresp", TXDM_RESP_OKAY, last_bresp);
        run <= 1'b1;
        // Misaligned write is refused and leaves the control word alone
        wr(4'h1, 32'h0);
        chk("bresp", TXDM_RESP_SLVERR, last_bresp);
        rd_chk("ctrl", TXDM_OFS_CTRL, 32'h3);
        chk("oe_n", 0, line_out_oe_n);
        // Every rail combination in dual-rail mode
        for (int i = 0; i < 4; i++) begin
            sym(PAT[i][1], PAT[i][0], 2);
            chk("plus", PAT[i][1] & ~PAT[i][0], line_out_plus);
            chk("minus", PAT[i][0] & ~PAT[i][1], line_out_minus);
        end
        wr(TXDM_OFS_CTRL, 32'h1);
        sym(1'b1, 1'b1, 2);
        chk("plus", 1, line_out_plus);
        chk("minus", 0, line_out_minus);
        transmitter_on <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("oe_n", 1, line_out_oe_n);
        transmitter_on <= 1'b1;
        wr(TXDM_OFS_CTRL, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk("oe_n", 1, line_out_oe_n);
        // Idle line through the external taps
        wr(TXDM_OFS_CTRL, 32'h3);
        wr(TXDM_OFS_INT_MASK, 32'h1);
        wr(TXDM_OFS_INT_STAT, 32'h3);
        sym(1'b0, 1'b0, 120);
        chk("fault", 0, drive_fault_flag);
        chk("irq", 0, irq);
        sym(1'b0, 1'b0, 16);
        chk("fault", 1, drive_fault_flag);
        chk("irq", 1, irq);
        rd_chk("status", TXDM_OFS_STATUS,
               (32'(TXDM_IDLE_LIMIT) << TXDM_STAT_CNT_LSB) | 32'h1);
        rd_chk("int_stat", TXDM_OFS_INT_STAT, 32'h1);
        wr(TXDM_OFS_INT_STAT, 32'h1);
        chk("irq", 0, irq);
        sym(1'b1, 1'b0, 1);
        sym(1'b0, 1'b0, 2);
        chk("fault", 0, drive_fault_flag);
        rd_chk("int_stat", TXDM_OFS_INT_STAT, 32'h2);
        // Internal source must ignore fake activity on the taps
        drop_mon <= 1'b1;
        wr(TXDM_OFS_INT_MASK, 32'h0);
        wr(TXDM_OFS_INT_STAT, 32'h3);
        wr(TXDM_OFS_CTRL, 32'h7);
        sym(1'b0, 1'b0, 136);
        chk("fault", 1, drive_fault_flag);
        chk("irq", 0, irq);
        rd_chk("int_stat", TXDM_OFS_INT_STAT, 32'h1);
        wr(TXDM_OFS_CTRL, 32'h3);
        sym(1'b0, 1'b0, 3);
        chk("fault", 0, drive_fault_flag);
        wrap_up();
    end
endmodule
`default_nettype wire

// ### dv/txdm_line_partner.sv
// Framer and transmit line model facing the drive monitor block
`default_nettype none
module txdm_line_partner (
    input  wire logic run,
    input  wire logic sym_pos,
    input  wire logic sym_neg,
    input  wire logic drop_mon,
    input  wire logic line_out_plus,
    input  wire logic line_out_minus,
    input  wire logic line_out_oe_n,
    output logic      tx_line_clock,
    output logic      tx_positive_rail_in,
    output logic      tx_negative_rail_in,
    output logic      monitor_plus_in,
    output logic      monitor_minus_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Line clock, 320 ns, parked low when no traffic is wanted
    // ------------------------------------------------------------
    initial begin
        tx_line_clock       = 1'b0;
        tx_positive_rail_in = 1'b0;
        tx_negative_rail_in = 1'b0;
    end
    always begin
        #160;
        if (run || tx_line_clock) begin
            tx_line_clock = ~tx_line_clock;
        end
    end

    // Rails change on the falling edge, far from the sampling edge
    always @(negedge tx_line_clock) begin
        tx_positive_rail_in <= sym_pos;
        tx_negative_rail_in <= sym_neg;
    end

    // Monitor taps through series resistors; a released line has no
    // differential, so both taps sit at the same level.
    // drop_mon holds a steady differential on the taps, so the external
    // source sees activity at every bit period whatever the line does.
    assign monitor_plus_in  = drop_mon ? 1'b1
                                       : (!line_out_oe_n && line_out_plus);
    assign monitor_minus_in = drop_mon ? 1'b0
                                       : (!line_out_oe_n && line_out_minus);
endmodule
`default_nettype wire

// ### src/txdm_drive_monitor.sv
// Transmit line driver with output drive monitor and AXI4-Lite registers
//
// Summary of operation
// R1: Sample negative rail on line clock edge
// R2: Single-rail: framer holds negative rail low
// R3: Positive pulse drives plus above minus
// R4: Negative pulse drives minus above plus
// R5: Transmitter off tri-states both line outputs
// R6: Fault after 128 idle bit periods
// R7: Internal monitor ignores external monitor pins
// R8: Fault low once pulse seen recently
// R9: Dual-rail data arrives already line encoded
// R10: Bit-period counter, cleared by each pulse
`default_nettype none
module txdm_drive_monitor
    import txdm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Line side
    input  wire logic        tx_line_clock,
    input  wire logic        tx_positive_rail_in,
    input  wire logic        tx_negative_rail_in,
    input  wire logic        transmitter_on,
    input  wire logic        monitor_plus_in,
    input  wire logic        monitor_minus_in,
    output logic             line_out_plus,
    output logic             line_out_minus,
    output logic             line_out_oe_n,
    output logic             drive_fault_flag,
    output logic             irq,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Bits: 0 clock, 1 pos, 2 neg, 3 tx on, 4 mon plus, 5 mon minus
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [5:0] sync3_q;
    logic       line_edge;
    logic       pos_s;
    logic       neg_s;
    logic       transmitter_on_pin_s;
    logic       mon_p_s;
    logic       mon_m_s;

    // Third stage holds the value seen just before the clock edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sync3_q <= 6'h00;
        end else begin
            sync1_q <= {monitor_minus_in, monitor_plus_in, transmitter_on,
                        tx_negative_rail_in, tx_positive_rail_in,
                        tx_line_clock};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Rails are taken one sample before the edge for setup margin
    assign line_edge  = sync2_q[0] & ~sync3_q[0];
    assign pos_s      = sync3_q[1];
    assign neg_s      = sync3_q[2];
    assign transmitter_on_pin_s = sync2_q[3];
    assign mon_p_s    = sync3_q[4];
    assign mon_m_s    = sync3_q[5];

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [1:0] int_stat_q;
    logic [1:0] int_mask_q;
    logic       tx_on;
    logic       dual_rail;
    logic       int_mon;
    logic       neg_eff;

    assign dual_rail = ctrl_q[TXDM_CTRL_DUAL_BIT];
    assign int_mon   = ctrl_q[TXDM_CTRL_INT_MON_BIT];
    // Either source at zero turns the driver off
    assign tx_on     = transmitter_on_pin_s & ctrl_q[TXDM_CTRL_TX_ON_BIT]; // R5
    // The negative rail has no meaning outside dual-rail mode
    assign neg_eff   = dual_rail & neg_s; // R2

    // ------------------------------------------------------------
    // Line output drive
    // ------------------------------------------------------------
    logic plus_q;
    logic minus_q;
    logic oe_n_q;

    // Both rails at once in dual-rail mode is no valid symbol, so nothing is sent
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            plus_q  <= 1'b0;
            minus_q <= 1'b0;
        end else if (line_edge) begin
            plus_q  <= pos_s & ~neg_eff;   // R3
            minus_q <= neg_eff & ~pos_s;   // R1 R4
        end
    end

    // Enable is active low; high impedance while off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~tx_on; // R5
        end
    end

    assign line_out_plus  = plus_q;
    assign line_out_minus = minus_q;
    assign line_out_oe_n  = oe_n_q;

    // ------------------------------------------------------------
    // Drive monitor
    // ------------------------------------------------------------
    logic [7:0] idle_cnt_q;
    logic       fault_q;
    logic       activity;
    logic       int_act;
    logic       ext_act;

    // Own output counts only while the driver is actually on
    assign int_act  = ~oe_n_q & (plus_q ^ minus_q);
    assign ext_act  = mon_p_s ^ mon_m_s;
    assign activity = int_mon ? int_act : ext_act; // R7

    // Saturating count of bit periods without a bipolar pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idle_cnt_q <= 8'h00;
        end else if (line_edge) begin
            if (activity) begin
                idle_cnt_q <= 8'h00; // R10
            end else if (idle_cnt_q != TXDM_IDLE_LIMIT) begin
                idle_cnt_q <= idle_cnt_q + 8'h01; // R10
            end
        end
    end

    // A stopped line clock freezes the count, a known limitation
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else if (line_edge) begin
            if (activity) begin
                fault_q <= 1'b0; // R8
            end else if (idle_cnt_q == TXDM_IDLE_LIMIT - 8'h01) begin
                fault_q <= 1'b1; // R6
            end
        end
    end

    assign drive_fault_flag = fault_q;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_go;
    logic        wr_map;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign wr_go  = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_map = (awaddr_q[1:0] == 2'h0);

    // Address and data are caught independently, in either order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Response; misaligned addresses answer with a slave error
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= TXDM_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? TXDM_RESP_OKAY : TXDM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------
    logic       wr_lane0;
    logic [1:0] int_event;
    logic [1:0] int_clr;

    assign wr_lane0  = wr_go & wr_map & wstrb_q[0];
    assign int_event = {line_edge & activity & fault_q,
                        line_edge & ~activity & ~fault_q &
                        (idle_cnt_q == TXDM_IDLE_LIMIT - 8'h01)};
    assign int_clr   = (wr_lane0 && awaddr_q == TXDM_OFS_INT_STAT) ?
                       wdata_q[1:0] : 2'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q     <= TXDM_CTRL_RESET;
            int_mask_q <= TXDM_MASK_RESET;
        end else if (wr_lane0) begin
            if (awaddr_q == TXDM_OFS_CTRL) begin
                ctrl_q <= wdata_q[2:0];
            end
            if (awaddr_q == TXDM_OFS_INT_MASK) begin
                int_mask_q <= wdata_q[1:0];
            end
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_stat_q <= 2'h0;
        end else begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_event;
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            TXDM_OFS_CTRL:     rd_mux[2:0] = ctrl_q;
            TXDM_OFS_STATUS: begin
                rd_mux[TXDM_STAT_FAULT_BIT] = fault_q;
                rd_mux[TXDM_STAT_CNT_LSB +: 8] = idle_cnt_q;
            end
            TXDM_OFS_INT_STAT: rd_mux[1:0] = int_stat_q;
            TXDM_OFS_INT_MASK: rd_mux[1:0] = int_mask_q;
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= TXDM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= (s_axi_araddr[1:0] == 2'h0) ? TXDM_RESP_OKAY
                                                     : TXDM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_neg_pulse_out: assert property ( // R1
        line_edge && dual_rail && neg_s && !pos_s
        |=> minus_q && !plus_q)
        else $error("negative rail sample gave no negative pulse");

    a_pos_pulse_out: assert property ( // R3
        line_edge && pos_s && !neg_eff |=> plus_q && !minus_q)
        else $error("positive rail sample gave no positive pulse");

    a_pulse_held: assert property ( // R1
        !line_edge |=> $stable(minus_q) && $stable(plus_q))
        else $error("line pulse changed within a bit period");

    a_tristate_off: assert property ( // R5
        !tx_on |=> line_out_oe_n)
        else $error("line driven while transmitter is off");

    a_fault_raise: assert property ( // R6
        line_edge && !activity && idle_cnt_q == TXDM_IDLE_LIMIT - 8'h01
        |=> drive_fault_flag && idle_cnt_q == TXDM_IDLE_LIMIT)
        else $error("fault not raised after idle limit");

    a_internal_src: assert property ( // R7
        line_edge && int_mon && !int_act |=> idle_cnt_q != 8'h00)
        else $error("external monitor pins used in internal mode");

    a_fault_clear: assert property ( // R8
        line_edge && activity |=> !drive_fault_flag ##1 !drive_fault_flag)
        else $error("fault stays high after a bipolar pulse");

    a_count_reset: assert property ( // R10
        line_edge && activity |=> idle_cnt_q == 8'h00)
        else $error("idle count not cleared by a pulse");

    a_count_hold: assert property ( // R10
        !line_edge |=> $stable(idle_cnt_q) && $stable(fault_q))
        else $error("monitor moved without a line clock edge");

    a_fault_sticky: assert property (
        $rose(fault_q) |-> int_stat_q[TXDM_INT_FAULT_SET_BIT])
        else $error("fault rise not recorded in status");

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");

    c_fault_rise:  cover property ($rose(drive_fault_flag));
    c_fault_fall:  cover property ($fell(drive_fault_flag));
    c_write_done:  cover property (s_axi_bvalid && s_axi_bready);
    c_read_done:   cover property (s_axi_rvalid && s_axi_rready);

endmodule
`default_nettype wire

// ### src/txdm_pkg.sv
// Constants for the transmit line drive and drive monitor block
`default_nettype none
package txdm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] TXDM_OFS_CTRL     = 4'h0;
    localparam logic [3:0] TXDM_OFS_STATUS   = 4'h4;
    localparam logic [3:0] TXDM_OFS_INT_STAT = 4'h8;
    localparam logic [3:0] TXDM_OFS_INT_MASK = 4'hc;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TXDM_CTRL_TX_ON_BIT    = 0;
    localparam int TXDM_CTRL_DUAL_BIT     = 1;
    localparam int TXDM_CTRL_INT_MON_BIT  = 2;
    localparam int TXDM_STAT_FAULT_BIT    = 0;
    localparam int TXDM_STAT_CNT_LSB      = 8;
    localparam int TXDM_INT_FAULT_SET_BIT = 0;
    localparam int TXDM_INT_FAULT_CLR_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] TXDM_CTRL_RESET = 3'h0;
    localparam logic [1:0] TXDM_MASK_RESET = 2'h0;

    // ------------------------------------------------------------
    // Monitor timing, in transmit bit periods
    // ------------------------------------------------------------
    localparam logic [7:0] TXDM_IDLE_LIMIT = 8'h80;

    // AXI responses
    localparam logic [1:0] TXDM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TXDM_RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire
